/* pmc_cfg.svh */
// Offsets, field positions and reset values of the power management capability header
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PMC_CAP_OFS 12'h0c0
`define PMC_LOCK_OFS 12'h0f8
`define PMC_STAT_OFS 12'h0fc

// ----------------------------------------------------------------------------
// Capability header fields
// ----------------------------------------------------------------------------
`define PMC_CAPABILITY_IDENTIFIER_MSB 7
`define PMC_CAPABILITY_IDENTIFIER_LSB 0
`define PMC_CAPABILITY_IDENTIFIER_VAL 8'h01
`define PMC_LINK_MSB 15
`define PMC_LINK_LSB 8
`define PMC_LINK_RST 8'hd0
`define PMC_VER_MSB 18
`define PMC_VER_LSB 16
`define PMC_VER_VAL 3'h3
`define PMC_EVCLK_BIT 19
`define PMC_RSVD_BIT 20
`define PMC_SPINIT_BIT 21
`define PMC_SPINIT_RST 1'h0
`define PMC_AUX_MSB 24
`define PMC_AUX_LSB 22
`define PMC_D1_BIT 25
`define PMC_D2_BIT 26
`define PMC_EVMASK_MSB 31
`define PMC_EVMASK_LSB 27
`define PMC_EVMASK_RST 5'h19

// ----------------------------------------------------------------------------
// Lock and status register fields
// ----------------------------------------------------------------------------
`define PMC_LOCK_BIT 0
`define PMC_LOCK_RST 1'h0
`define PMC_STAT_STATE_MSB 2
`define PMC_STAT_STATE_LSB 0
`define PMC_STAT_LOCK_BIT 3
`define PMC_STAT_FWD_BIT 4

`endif

/* pmc_pkg.sv */
// Types shared by the power management capability header block
package pmc_pkg;

  // Power state of the port as driven by the port's power logic
  typedef enum logic [2:0] {
    PMC_D0,
    PMC_D1,
    PMC_D2,
    PMC_D3HOT,
    PMC_D3COLD
  } pmc_pstate_e;

  // All state of the register bank
  typedef struct packed {
    logic [7:0] next_link;
    logic spec_init;
    logic [4:0] event_mask;
    logic lock;
    logic [31:0] rdata;
    logic slverr;
  } pmc_regs_s;

  // All state of the event gate
  typedef struct packed {
    logic fwd;
  } pmc_gate_s;

endpackage

/* pmc_event_gate.sv */
// Forwarding gate for power management event messages, fixed to the reset mask
`timescale 1ns/100ps
`include "pmc_cfg.svh"

module pmc_event_gate (
  input wire logic pclk,
  input wire logic presetn,
  input wire pmc_pkg::pmc_pstate_e pm_state,
  input wire logic pme_in,
  output logic pme_fwd
);
  import pmc_pkg::*;

  // Behaviour follows the reset pattern except in D3cold, never the register that software writes
  localparam logic [4:0] FIXED_MASK = `PMC_EVMASK_RST;

  pmc_gate_s q;
  pmc_gate_s d;
  logic permit;

  // ----------------------------------------------------------------------------
  // Per-state permission
  // ----------------------------------------------------------------------------
  // Decode the fixed mask per state; D3cold is forced off and never reads mask bit 4
  always_comb begin
    case (pm_state)
      PMC_D0: permit = FIXED_MASK[0];
      PMC_D1: permit = FIXED_MASK[1];
      PMC_D2: permit = FIXED_MASK[2];
      PMC_D3HOT: permit = FIXED_MASK[3];
      PMC_D3COLD: permit = 1'b0;
      default: permit = 1'b0;
    endcase
  end

  // Next state: a one-cycle forward pulse per accepted event
  always_comb begin
    d = q;
    d.fwd = pme_in && permit;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pme_fwd = q.fwd;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_no_fwd_cold;
    (pm_state == PMC_D3COLD) |=> !pme_fwd;
  endproperty
  a_no_fwd_cold: assert property (p_no_fwd_cold) else $error("event forwarded in D3cold");

  property p_fwd_fixed;
    (pme_in && (pm_state == PMC_D0 || pm_state == PMC_D3HOT)) |=> pme_fwd;
  endproperty
  a_fwd_fixed: assert property (p_fwd_fixed) else $error("event not forwarded");

  property p_no_fwd_mid;
    (pm_state == PMC_D1 || pm_state == PMC_D2 || !pme_in) |=> !pme_fwd;
  endproperty
  a_no_fwd_mid: assert property (p_no_fwd_mid) else $error("stray event forward");

  c_fwd_d3hot: cover property (pme_in && pm_state == PMC_D3HOT ##1 pme_fwd);

endmodule

/* pmc_cap_regs.sv */
// APB register bank for the power management capability header word
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`include "pmc_cfg.svh"

// ----------------------------------------------------------------------------
// Operation
// - Low byte always reads 0x01 and ignores writes.
// - Byte one holds the next capability link, writable while unlocked.
// - Version field reads fixed 0x3 and is read-only.
// - Event clock bit 19 always reads zero.
// - Special init bit 21 resets to zero, writable while unlocked.
// - Auxiliary current field bits 24:22 always read zero.
// - D1 support bit 25 always reads zero.
// - D2 support bit 26 always reads zero.
// - Five-bit event state mask, writable while unlocked, resets to 0b11001.
// - Reset mask sets bits 27, 30 and 31; only D0 and D3hot (bits 27 and 30) are forwarded.
// - No event forwarding while in unpowered D3.
// - Writing the mask changes read-back only, not actual forwarding.
// ----------------------------------------------------------------------------

module pmc_cap_regs #(
  parameter int ADDR_W = 12,
  parameter logic [7:0] NEXT_LINK_RST = `PMC_LINK_RST
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pmc_pkg::pmc_pstate_e pm_state,
  input wire logic pme_in,
  output logic pme_fwd
);
  import pmc_pkg::*;

  // ----------------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------------
  // Offsets need eight address bits; the link must point at a whole word
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 8 and 32");
  end
  if (NEXT_LINK_RST[1:0] != 2'h0) begin : g_bad_link
    $error("NEXT_LINK_RST must be word aligned");
  end

  // ----------------------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------------------
  localparam int IDX_W = ADDR_W - 2;
  localparam logic [IDX_W-1:0] CAP_IDX = IDX_W'(`PMC_CAP_OFS >> 2);
  localparam logic [IDX_W-1:0] LOCK_IDX = IDX_W'(`PMC_LOCK_OFS >> 2);
  localparam logic [IDX_W-1:0] STAT_IDX = IDX_W'(`PMC_STAT_OFS >> 2);

  // Reset image of the whole bank; constants only, as async reset demands
  localparam pmc_regs_s RST = '{
    next_link: NEXT_LINK_RST,
    spec_init: `PMC_SPINIT_RST,
    event_mask: `PMC_EVMASK_RST,
    lock: `PMC_LOCK_RST,
    rdata: 32'h0000_0000,
    slverr: 1'b0
  };

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  pmc_regs_s q;
  pmc_regs_s d;
  logic [IDX_W-1:0] word_idx;
  logic hit_cap;
  logic hit_lock;
  logic hit_stat;
  logic hit_any;
  logic setup;
  logic acc;
  logic acc_wr;
  logic cap_wr_ok;
  logic fwd;

  // ----------------------------------------------------------------------------
  // Read images
  // ----------------------------------------------------------------------------
  // Header word; constant fields are built here so no write path can reach them
  function automatic logic [31:0] cap_word(input pmc_regs_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`PMC_CAPABILITY_IDENTIFIER_MSB:`PMC_CAPABILITY_IDENTIFIER_LSB] = `PMC_CAPABILITY_IDENTIFIER_VAL;
    w[`PMC_LINK_MSB:`PMC_LINK_LSB] = s.next_link;
    w[`PMC_VER_MSB:`PMC_VER_LSB] = `PMC_VER_VAL;
    w[`PMC_SPINIT_BIT] = s.spec_init;
    w[`PMC_EVMASK_MSB:`PMC_EVMASK_LSB] = s.event_mask;
    return w;
  endfunction

  // Status word shows live state of the port and of the bank
  function automatic logic [31:0] stat_word(input pmc_regs_s s, input pmc_pstate_e st,
                                            input logic f);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`PMC_STAT_STATE_MSB:`PMC_STAT_STATE_LSB] = st;
    w[`PMC_STAT_LOCK_BIT] = s.lock;
    w[`PMC_STAT_FWD_BIT] = f;
    return w;
  endfunction

  // ----------------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------------
  // Word decode; the two low address bits are ignored
  assign word_idx = paddr[ADDR_W-1:2];
  assign hit_cap = (word_idx == CAP_IDX);
  assign hit_lock = (word_idx == LOCK_IDX);
  assign hit_stat = (word_idx == STAT_IDX);
  assign hit_any = hit_cap || hit_lock || hit_stat;

  // Phases of the transfer; the bank never inserts wait states
  assign setup = psel && !penable;
  assign acc = psel && penable;
  assign acc_wr = acc && pwrite;
  assign cap_wr_ok = acc_wr && hit_cap && !q.lock;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  // Read data is latched in setup so prdata comes straight from a flip-flop
  always_comb begin
    d = q;
    if (setup) begin
      d.slverr = !hit_any;
      if (pwrite || !hit_any) begin
        d.rdata = 32'h0000_0000;
      end else if (hit_cap) begin
        d.rdata = cap_word(q);
      end else if (hit_lock) begin
        d.rdata = {31'h0000_0000, q.lock};
      end else begin
        d.rdata = stat_word(q, pm_state, fwd);
      end
    end
    // Only the lockable bytes take data; lanes 0 and the fixed bits are dropped
    if (cap_wr_ok) begin
      if (pstrb[1]) begin
        d.next_link = pwdata[`PMC_LINK_MSB:`PMC_LINK_LSB];
      end
      if (pstrb[2]) begin
        d.spec_init = pwdata[`PMC_SPINIT_BIT];
      end
      if (pstrb[3]) begin
        // Read-back only: the event gate never sees this field
        d.event_mask = pwdata[`PMC_EVMASK_MSB:`PMC_EVMASK_LSB];
      end
    end
    // Lock may be set and cleared by software; status register ignores writes
    if (acc_wr && hit_lock && pstrb[0]) begin
      d.lock = pwdata[`PMC_LOCK_BIT];
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  // Zero-wait answer; error flag only inside the access phase
  assign pready = acc;
  assign pslverr = acc && q.slverr;
  assign prdata = q.rdata;
  assign pme_fwd = fwd;

  // ----------------------------------------------------------------------------
  // Event forwarding
  // ----------------------------------------------------------------------------
  // Kept apart so the advertised mask cannot leak into real behaviour
  pmc_event_gate u_gate (
    .pclk(pclk),
    .presetn(presetn),
    .pm_state(pm_state),
    .pme_in(pme_in),
    .pme_fwd(fwd)
  );

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic rd_cap;
  assign rd_cap = acc && !pwrite && hit_cap;

  property p_capability_identifier;
    rd_cap |-> prdata[`PMC_CAPABILITY_IDENTIFIER_MSB:`PMC_CAPABILITY_IDENTIFIER_LSB] == `PMC_CAPABILITY_IDENTIFIER_VAL;
  endproperty
  a_capability_identifier: assert property (p_capability_identifier) else $error("capability id wrong");

  property p_link_wr;
    (cap_wr_ok && pstrb[1]) |=> q.next_link == $past(pwdata[15:8]);
  endproperty
  a_link_wr: assert property (p_link_wr) else $error("next link not written");

  property p_locked;
    (acc_wr && hit_cap && q.lock) |=> $stable(q.next_link) && $stable(q.spec_init)
      && $stable(q.event_mask);
  endproperty
  a_locked: assert property (p_locked) else $error("locked field changed");

  property p_version;
    rd_cap |-> prdata[`PMC_VER_MSB:`PMC_VER_LSB] == `PMC_VER_VAL;
  endproperty
  a_version: assert property (p_version) else $error("version field wrong");

  property p_zero_bits;
    rd_cap |-> prdata[`PMC_D2_BIT:`PMC_AUX_LSB] == 5'h00 && !prdata[`PMC_EVCLK_BIT];
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("fixed zero bit set");

  property p_spinit_cause;
    $rose(q.spec_init) |-> $past(cap_wr_ok && pstrb[2]);
  endproperty
  a_spinit_cause: assert property (p_spinit_cause) else $error("init bit set by itself");

  property p_mask_cause;
    !$stable(q.event_mask) |-> $past(cap_wr_ok && pstrb[3]);
  endproperty
  a_mask_cause: assert property (p_mask_cause) else $error("mask changed by itself");

  // Expected mask comes from the written data, not from the bank's own copy
  property p_mask_readback;
    (cap_wr_ok && pstrb[3]) ##1 (setup && !pwrite && hit_cap) |=>
      prdata[`PMC_EVMASK_MSB:`PMC_EVMASK_LSB] == $past(pwdata[31:27], 2);
  endproperty
  a_mask_readback: assert property (p_mask_readback) else $error("mask read-back wrong");

  property p_rsvd;
    rd_cap |-> !prdata[`PMC_RSVD_BIT];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");

  property p_unmapped;
    (acc && !hit_any) |-> pslverr && pready;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  // Read after an idle cycle, the usual spacing of a simple master
  property p_mask_late;
    (cap_wr_ok && pstrb[3]) ##2 (setup && !pwrite && hit_cap) |=>
      prdata[`PMC_EVMASK_MSB:`PMC_EVMASK_LSB] == $past(pwdata[31:27], 3);
  endproperty
  a_mask_late: assert property (p_mask_late) else $error("mask read late wrong");

  property p_spinit_wr;
    (cap_wr_ok && pstrb[2]) |=> q.spec_init == $past(pwdata[`PMC_SPINIT_BIT]);
  endproperty
  a_spinit_wr: assert property (p_spinit_wr) else $error("init bit not written");

  property p_mask_wr;
    (cap_wr_ok && pstrb[3]) |=> q.event_mask == $past(pwdata[31:27]);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask not written");

  property p_link_cause;
    !$stable(q.next_link) |-> $past(cap_wr_ok && pstrb[1]);
  endproperty
  a_link_cause: assert property (p_link_cause) else $error("link changed by itself");

  // A header write without lane one must leave the link alone
  property p_link_lane;
    (cap_wr_ok && !pstrb[1]) |=> $stable(q.next_link);
  endproperty
  a_link_lane: assert property (p_link_lane) else $error("link written without lane");

  // Read data stands from one setup cycle to the next
  property p_rdata_hold;
    !setup |=> $stable(prdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_wr_rdata;
    (setup && pwrite) |=> prdata == 32'h0000_0000;
  endproperty
  a_wr_rdata: assert property (p_wr_rdata) else $error("write returned data");

  property p_bad_rdata;
    (setup && !hit_any) |=> prdata == 32'h0000_0000;
  endproperty
  a_bad_rdata: assert property (p_bad_rdata) else $error("unmapped read data");

  property p_lock_wr;
    (acc_wr && hit_lock && pstrb[0]) |=> q.lock == $past(pwdata[`PMC_LOCK_BIT]);
  endproperty
  a_lock_wr: assert property (p_lock_wr) else $error("lock not written");

  // Main scenarios
  c_cap_read: cover property (setup && hit_cap && !pwrite ##1 rd_cap);
  c_cap_write: cover property (cap_wr_ok && pstrb[3]);
  c_locked_write: cover property (acc_wr && hit_cap && q.lock);
  c_fwd: cover property (pme_in ##1 pme_fwd);

endmodule

/* testbench.sv */
// Self-checking APB bench for the power management capability header block
`timescale 1ns/100ps
`include "pmc_cfg.svh"

module testbench;
  import pmc_pkg::*;

  // ---------------------------------------------------------------------------
  // Constants and signals
  // ---------------------------------------------------------------------------
  localparam logic [7:0] LINK_RST = 8'hd0;
  // Reset image from the fields: mask, d2, d1, aux, spinit, rsvd, evclk, ver, link, id
  localparam logic [31:0] HDR_RST = {5'b11001, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0, 3'h3,
                                     LINK_RST, 8'h01};
  localparam logic [11:0] BAD_OFS = 12'h100;
  logic pclk;
  logic presetn;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pmc_pstate_e pm_state;
  logic pme_in;
  logic pme_fwd;
  logic [31:0] rd;
  logic er;
  int err_count;
  int num_checks;

  pmc_cap_regs #(.ADDR_W(12), .NEXT_LINK_RST(LINK_RST)) u_pmc_cap_regs (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pm_state(pm_state), .pme_in(pme_in), .pme_fwd(pme_fwd)
  );

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  // Case equality so an unknown never counts as a match
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
    num_checks++;
    if (seen !== x) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, seen);
    end
  endtask

  // One APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk("pready", {31'h0, pready}, 32'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(a, 1'b1, d, s, rd, er);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0, 4'hf, rd, er);
    chk(nm, rd, x);
  endtask

  // Pulse one event in a state; forwarded pulse is registered, look at mid-cycle
  task automatic ev(input pmc_pstate_e st, input logic x);
    @(posedge pclk);
    pm_state <= st;
    pme_in <= 1'b1;
    @(posedge pclk);
    pme_in <= 1'b0;
    @(negedge pclk);
    chk("pme_fwd", {31'h0, pme_fwd}, {31'h0, x});
    @(negedge pclk);
    chk("pme_fwd_end", {31'h0, pme_fwd}, 32'h0);
  endtask

  // Every power state once
  task automatic ev_all;
    ev(PMC_D0, 1'b1);
    ev(PMC_D1, 1'b0);
    ev(PMC_D2, 1'b0);
    ev(PMC_D3HOT, 1'b1);
    ev(PMC_D3COLD, 1'b0);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Watchdog and main sequence
  // ---------------------------------------------------------------------------
  // Whole sequence needs about a hundred cycles; this margin only cuts a hang
  initial begin
    repeat (5000) @(posedge pclk);
    $display("CHECK FAILED watchdog expected done seen hang");
    err_count++;
    tally_and_finish;
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    paddr = 12'h0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    pm_state = PMC_D0;
    pme_in = 1'b0;
    err_count = 0;
    num_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc("hdr_reset", `PMC_CAP_OFS, HDR_RST);
    rdc("lock_reset", `PMC_LOCK_OFS, 32'h0);
    ev_all;
    // All ones then all zeros: only link, bit 21 and mask may move
    wr(`PMC_CAP_OFS, 32'hffff_ffff, 4'hf);
    rdc("hdr_ones", `PMC_CAP_OFS, 32'hf823_ff01);
    wr(`PMC_CAP_OFS, 32'h0, 4'hf);
    rdc("hdr_zero", `PMC_CAP_OFS, 32'h0003_0001);
    ev_all;
    // Single lane strobe touches the link byte only
    wr(`PMC_CAP_OFS, 32'hffff_ffff, 4'b0010);
    rdc("hdr_strobe", `PMC_CAP_OFS, 32'h0003_ff01);
    // Locked header ignores writes
    wr(`PMC_LOCK_OFS, 32'h1, 4'h1);
    rdc("lock_set", `PMC_LOCK_OFS, 32'h1);
    wr(`PMC_CAP_OFS, 32'hffff_ffff, 4'hf);
    rdc("hdr_locked", `PMC_CAP_OFS, 32'h0003_ff01);
    @(posedge pclk);
    pm_state <= PMC_D3HOT;
    rdc("status", `PMC_STAT_OFS, 32'h0000_000b);
    wr(`PMC_LOCK_OFS, 32'h0, 4'h1);
    wr(`PMC_CAP_OFS, 32'hffff_ffff, 4'hf);
    rdc("hdr_unlocked", `PMC_CAP_OFS, 32'hf823_ff01);
    // Unmapped word: error, zero data, write without effect
    apb(BAD_OFS, 1'b0, 32'h0, 4'hf, rd, er);
    chk("bad_rdata", rd, 32'h0);
    chk("bad_err", {31'h0, er}, 32'h1);
    apb(BAD_OFS, 1'b1, 32'h0, 4'hf, rd, er);
    chk("bad_wr_err", {31'h0, er}, 32'h1);
    rdc("hdr_after_bad", `PMC_CAP_OFS, 32'hf823_ff01);
    // Lanes two and three without lane one: link kept, init bit and mask cleared
    wr(`PMC_CAP_OFS, 32'h0, 4'b1101);
    rdc("hdr_lanes", `PMC_CAP_OFS, 32'h0003_ff01);
    // Second reset in mid-run restores the image
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc("hdr_rereset", `PMC_CAP_OFS, HDR_RST);
    rdc("lock_rereset", `PMC_LOCK_OFS, 32'h0);
    tally_and_finish;
  end
endmodule
